/* File: hdl/ebu_pkg.sv */
// Package of constants and types for the external bus unit
package ebu_pkg;

  // ****************************************************************
  // Bus modes
  // ****************************************************************
  localparam logic [2:0] MODE_SINGLE   = 3'h0;
  localparam logic [2:0] MODE_DEMUX16  = 3'h1;
  localparam logic [2:0] MODE_MUX16    = 3'h2;
  localparam logic [2:0] MODE_MUX8     = 3'h3;
  localparam logic [2:0] MODE_DEMUX8   = 3'h4;

  // Address space sizes
  localparam logic [1:0] SPACE_16M     = 2'h0;
  localparam logic [1:0] SPACE_1M      = 2'h1;
  localparam logic [1:0] SPACE_256K    = 2'h2;
  localparam logic [1:0] SPACE_64K     = 2'h3;

  // ****************************************************************
  // Bus configuration word layout
  // ****************************************************************
  localparam int CFG_W          = 16;
  localparam int CFG_MODE_LO    = 0;   // 3 bits
  localparam int CFG_CYC_LO     = 3;   // 4 bits, memory cycle wait states
  localparam int CFG_TRI_BIT    = 7;   // tri-state wait state
  localparam int CFG_ALE_BIT    = 8;   // lengthened address latch
  localparam int CFG_RWD_BIT    = 9;   // delayed read/write strobe
  localparam int CFG_RDYEN_BIT  = 10;  // ready function enable
  localparam int CFG_READY_POLARITY_BIT_BIT = 11;  // ready active level
  localparam int CFG_CSEN_BIT   = 12;  // chip select enable

  localparam int NUM_WIN   = 4;
  localparam int ADDR_W    = 24;
  localparam int DATA_W    = 16;
  localparam int SEG_W     = 8;
  localparam int CYC_W     = 4;

  localparam logic [CYC_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CYC_W-1:0] CNT_ONE  = 4'h1;

  // Active-low chip select idle pattern
  localparam logic [NUM_WIN:0] CS_IDLE = 5'h1F;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_ALE   = 7'h02,
    ST_DLY   = 7'h04,
    ST_STRB  = 7'h08,
    ST_RDY   = 7'h10,
    ST_TRI   = 7'h20,
    ST_HOLD  = 7'h40
  } bus_state_t;

endpackage : ebu_pkg

/* File: hdl/win_sel_if.sv */
// Interface carrying window decode request and result
interface win_sel_if;
  import ebu_pkg::*;
  logic [ADDR_W-1:0]  addr;
  logic [NUM_WIN-1:0] hit;
  logic [2:0]         sel;
  modport decoder (input addr, output hit, output sel);
  modport user    (output addr, input hit, input sel);
endinterface : win_sel_if

/* File: hdl/window_decoder.sv */
// Address window decoder with hierarchical priority
module window_decoder
  import ebu_pkg::*;
(
  input  wire logic [NUM_WIN*ADDR_W-1:0] i_win_base,
  input  wire logic [NUM_WIN*ADDR_W-1:0] i_win_mask,
  input  wire logic [NUM_WIN-1:0]        i_win_en,
  win_sel_if.decoder                     ws
);

  genvar g;
  generate
    for (g = 0; g < NUM_WIN; g++) begin : g_hit
      assign ws.hit[g] = i_win_en[g] &&
        (((ws.addr ^ i_win_base[g*ADDR_W +: ADDR_W]) &
          i_win_mask[g*ADDR_W +: ADDR_W]) == '0);
    end
  endgenerate

  // Window 4 over 3 and 2 over 1; 0 means the default region
  always_comb begin
    if (ws.hit[3]) begin
      ws.sel = 3'h4;
    end else if (ws.hit[2]) begin
      ws.sel = 3'h3;
    end else if (ws.hit[1]) begin
      ws.sel = 3'h2;
    end else if (ws.hit[0]) begin
      ws.sel = 3'h1;
    end else begin
      ws.sel = 3'h0;
    end
  end

endmodule : window_decoder

/* File: hdl/external_bus_unit.sv */
// External bus unit: mode, timing, windows, chip selects, ready, arbitration
//
// Function
// - Supports single-chip mode and four external modes of 8 or 16 bit data, muxed or demuxed.
// - Demuxed modes drive address on the address port and data on the full or low-byte port.
// - Muxed modes share one port for address and then data within each cycle.
// - Cycle time, tri-state time, latch strobe length and strobe delay are set per config.
// - Four address windows each carry their own select and bus configuration.
// - Overlapping windows resolve with window 4 over 3 and window 2 over 1.
// - Accesses outside all windows use the default bus configuration.
// - Five active-low chip selects, one per window plus one for the default region.
// - With ready enabled the cycle waits for the ready level given by the polarity bit.
// - Setting the arbitration enable bit hands request, grant and hold pins to the unit.
// - After reset the unit is master; setting the grant direction bit makes it a slave.
// - The address space limit selects eight, four, two or no segment address lines.
// - Chip selects change half a clock after the latch strobe rises, or with it if selected.
module external_bus_unit
  import ebu_pkg::*;
(
  input  wire logic                      i_clk,
  input  wire logic                      i_rst_n,
  // CPU request side
  input  wire logic                      i_req,
  input  wire logic                      i_we,
  input  wire logic                      i_byte,
  input  wire logic [ADDR_W-1:0]         i_addr,
  input  wire logic [DATA_W-1:0]         i_wdata,
  output logic                           o_ack,
  output logic [DATA_W-1:0]              o_rdata,
  // Configuration
  input  wire logic [CFG_W-1:0]          i_default_bus_config,
  input  wire logic [NUM_WIN*CFG_W-1:0]  i_window_bus_config,
  input  wire logic [NUM_WIN*ADDR_W-1:0] i_window_address_select,
  input  wire logic [NUM_WIN*ADDR_W-1:0] i_window_mask,
  input  wire logic [1:0]                i_space_size,
  input  wire logic                      i_chip_select_timing_sel,
  input  wire logic                      i_arbitration_enable_bit,
  input  wire logic                      i_grant_pin_direction_bit,
  // Pins
  output logic [DATA_W-1:0]              o_shared_addr_data_port,
  output logic [DATA_W-1:0]              o_shared_oe,
  input  wire logic [DATA_W-1:0]         i_shared_addr_data_port,
  output logic [DATA_W-1:0]              o_dedicated_address_port,
  output logic [SEG_W-1:0]               o_segment_port,
  output logic                           o_ale,
  output logic                           o_rd_n,
  output logic                           o_wr_n,
  output logic [NUM_WIN:0]               o_cs_n,
  input  wire logic                      i_ready,
  input  wire logic                      i_hold_n,
  output logic                           o_bus_request_out_n,
  output logic                           o_bus_grant_ack,
  output logic                           o_bus_grant_ack_oe,
  input  wire logic                      i_bus_grant_ack,
  output logic                           o_busy
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [2:0] rdy_s, hold_s, bus_grant_ack_s;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rdy_s  <= 3'h0;
      hold_s <= 3'h7;
      bus_grant_ack_s <= 3'h7;
    end else begin
      rdy_s  <= {rdy_s[1:0], i_ready};
      hold_s <= {hold_s[1:0], i_hold_n};
      bus_grant_ack_s <= {bus_grant_ack_s[1:0], i_bus_grant_ack};
    end
  end

  logic ready_q, hold_n_q, bus_grant_ack_in_q;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ready_q   <= 1'b0;
      hold_n_q  <= 1'b1;
      bus_grant_ack_in_q <= 1'b1;
    end else begin
      if (rdy_s[1] == rdy_s[2]) ready_q <= rdy_s[2];
      if (hold_s[1] == hold_s[2]) hold_n_q <= hold_s[2];
      if (bus_grant_ack_s[1] == bus_grant_ack_s[2]) bus_grant_ack_in_q <= bus_grant_ack_s[2];
    end
  end

  // ****************************************************************
  // Window decode
  // ****************************************************************
  win_sel_if ws ();
  assign ws.addr = i_addr;

  window_decoder u_dec (
    .i_win_base (i_window_address_select),
    .i_win_mask (i_window_mask),
    .i_win_en   ({NUM_WIN{1'b1}}),
    .ws         (ws)
  );

  logic [CFG_W-1:0] next_cfg;
  always_comb begin
    next_cfg = i_default_bus_config;
    if (ws.sel != 3'h0) begin
      next_cfg = i_window_bus_config[(ws.sel - 3'h1)*CFG_W +: CFG_W];
    end
  end

  // ****************************************************************
  // Bus cycle sequencer
  // ****************************************************************
  bus_state_t       state;
  logic [CFG_W-1:0] cfg;
  logic [2:0]       win;
  logic [CYC_W-1:0] cnt;
  logic             we_q;
  logic             byte_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic             cs_half;

  logic [2:0] mode;
  logic       is_mux, is_8bit, cfg_rdy_en, cfg_rdy_pol;
  assign mode        = cfg[CFG_MODE_LO +: 3];
  assign is_mux      = (mode == MODE_MUX16) || (mode == MODE_MUX8);
  assign is_8bit     = (mode == MODE_MUX8) || (mode == MODE_DEMUX8);
  assign cfg_rdy_en  = cfg[CFG_RDYEN_BIT];
  assign cfg_rdy_pol = cfg[CFG_READY_POLARITY_BIT_BIT];

  logic [2:0] next_mode;
  logic       hold_req, slave;
  assign next_mode = next_cfg[CFG_MODE_LO +: 3];
  assign slave     = i_grant_pin_direction_bit;
  // Master grants on hold; slave holds until the master's active-low grant appears
  assign hold_req  = i_arbitration_enable_bit && (slave ? bus_grant_ack_in_q : !hold_n_q);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
      cnt   <= CNT_ZERO;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (hold_req) begin
            state <= ST_HOLD;
          end else if (i_req && !o_ack && next_mode != MODE_SINGLE) begin
            state <= ST_ALE;
            cnt   <= next_cfg[CFG_ALE_BIT] ? CNT_ONE : CNT_ZERO;
          end
        end
        ST_ALE: begin
          if (cnt != CNT_ZERO) begin
            cnt <= cnt - CNT_ONE;
          end else if (cfg[CFG_RWD_BIT]) begin
            state <= ST_DLY;
          end else begin
            state <= ST_STRB;
            cnt   <= cfg[CFG_CYC_LO +: CYC_W];
          end
        end
        ST_DLY: begin
          state <= ST_STRB;
          cnt   <= cfg[CFG_CYC_LO +: CYC_W];
        end
        ST_STRB: begin
          if (cnt != CNT_ZERO) begin
            cnt <= cnt - CNT_ONE;
          end else if (cfg_rdy_en) begin
            state <= ST_RDY;
          end else begin
            state <= ST_TRI;
            cnt   <= cfg[CFG_TRI_BIT] ? CNT_ONE : CNT_ZERO;
          end
        end
        ST_RDY: begin
          if (ready_q == cfg_rdy_pol) begin
            state <= ST_TRI;
            cnt   <= cfg[CFG_TRI_BIT] ? CNT_ONE : CNT_ZERO;
          end
        end
        ST_TRI: begin
          if (cnt != CNT_ZERO) begin
            cnt <= cnt - CNT_ONE;
          end else begin
            state <= ST_IDLE;
          end
        end
        ST_HOLD: begin
          if (!hold_req) state <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cfg     <= '0;
      win     <= 3'h0;
      we_q    <= 1'b0;
      byte_q  <= 1'b0;
      addr_q  <= '0;
      wdata_q <= '0;
    end else if (state == ST_IDLE && i_req && !o_ack && !hold_req) begin
      cfg     <= next_cfg;
      win     <= ws.sel;
      we_q    <= i_we;
      byte_q  <= i_byte;
      addr_q  <= i_addr;
      wdata_q <= i_wdata;
    end
  end

  // Single-chip requests are answered at once without external activity
  // Strobe pins trail the state by a clock, so a timed read is taken one cycle later
  logic timed_end;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_ack     <= 1'b0;
      o_rdata   <= '0;
      timed_end <= 1'b0;
    end else begin
      o_ack     <= 1'b0;
      timed_end <= (state == ST_STRB) && (cnt == CNT_ZERO) && !cfg_rdy_en;
      if (state == ST_IDLE && i_req && !o_ack && !hold_req && next_mode == MODE_SINGLE) begin
        o_ack <= 1'b1;
      end
      if (timed_end) begin
        o_ack   <= 1'b1;
        o_rdata <= is_8bit ? {8'h00, i_shared_addr_data_port[7:0]} : i_shared_addr_data_port;
      end
      if (state == ST_RDY && ready_q == cfg_rdy_pol) begin
        o_ack   <= 1'b1;
        o_rdata <= is_8bit ? {8'h00, i_shared_addr_data_port[7:0]} : i_shared_addr_data_port;
      end
    end
  end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  logic in_cycle, strobe;
  assign in_cycle = (state == ST_ALE) || (state == ST_DLY) || (state == ST_STRB) ||
                    (state == ST_RDY);
  assign strobe   = (state == ST_STRB) || (state == ST_RDY);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_ale                    <= 1'b0;
      o_rd_n                   <= 1'b1;
      o_wr_n                   <= 1'b1;
      o_shared_addr_data_port  <= '0;
      o_shared_oe              <= '0;
      o_dedicated_address_port <= '0;
      o_busy                   <= 1'b0;
    end else begin
      o_ale  <= (state == ST_ALE);
      o_rd_n <= !(strobe && !we_q);
      o_wr_n <= !(strobe && we_q);
      o_busy <= in_cycle || (state == ST_TRI);
      o_dedicated_address_port <= is_mux ? '0 : addr_q[DATA_W-1:0];
      if (state == ST_ALE && is_mux) begin
        o_shared_addr_data_port <= addr_q[DATA_W-1:0];
        o_shared_oe             <= '1;
      end else if ((state == ST_DLY || strobe) && we_q) begin
        o_shared_addr_data_port <= wdata_q;
        o_shared_oe             <= (is_8bit || byte_q) ? 16'h00FF : 16'hFFFF;
      end else begin
        o_shared_oe             <= '0;
      end
    end
  end

  // Upper address lines per restricted address space
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_segment_port <= '0;
    end else begin
      unique case (i_space_size)
        SPACE_16M:  o_segment_port <= addr_q[ADDR_W-1:DATA_W];
        SPACE_1M:   o_segment_port <= {4'h0, addr_q[DATA_W+3:DATA_W]};
        SPACE_256K: o_segment_port <= {6'h00, addr_q[DATA_W+1:DATA_W]};
        SPACE_64K:  o_segment_port <= 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // Chip selects
  // ****************************************************************
  // Fabric has one edge; the half-cycle lag is modelled as one extra cycle
  logic [NUM_WIN:0] cs_val;
  always_comb begin
    cs_val = CS_IDLE;
    if (in_cycle && (state != ST_ALE || cs_half) && cfg[CFG_CSEN_BIT]) cs_val[win] = 1'b0;
    if (state == ST_ALE && cfg[CFG_CSEN_BIT] && i_chip_select_timing_sel) cs_val[win] = 1'b0;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cs_half <= 1'b0;
      o_cs_n  <= CS_IDLE;
    end else begin
      cs_half <= (state == ST_ALE);
      o_cs_n  <= cs_val;
    end
  end

  // ****************************************************************
  // Arbitration pins
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_bus_request_out_n <= 1'b1;
      o_bus_grant_ack     <= 1'b1;
      o_bus_grant_ack_oe  <= 1'b1;
    end else begin
      o_bus_grant_ack_oe  <= !(i_arbitration_enable_bit && slave);
      o_bus_grant_ack     <= !(state == ST_HOLD && !slave);
      o_bus_request_out_n <= !(state == ST_HOLD && i_req);
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  ready_wait_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state == ST_RDY && ready_q != cfg_rdy_pol) |=> (state == ST_RDY))
    else $error("ready wait left early");
  ready_end_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state == ST_RDY && ready_q == cfg_rdy_pol) |=> o_ack && state == ST_TRI)
    else $error("ready level did not end cycle");
  no_ready_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state == ST_STRB && cnt == CNT_ZERO && !cfg_rdy_en) |-> ##2 o_ack)
    else $error("timed cycle did not end");
  single_chip_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state == ST_IDLE && i_req && !o_ack && !hold_req && next_mode == MODE_SINGLE)
    |=> o_ack && state == ST_IDLE)
    else $error("single chip access went external");
  win_prio_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ws.hit[3] |-> ws.sel == 3'h4)
    else $error("window 4 not highest");
  default_cfg_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (ws.hit == '0) |-> next_cfg == i_default_bus_config)
    else $error("default config not used");
  one_cs_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $countones(~o_cs_n) <= 1)
    else $error("more than one chip select");
  cs_late_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (cs_half && !i_chip_select_timing_sel && cfg[CFG_CSEN_BIT]) |=> !o_cs_n[win])
    else $error("chip select late");
  mux_addr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state == ST_ALE && is_mux) |=> o_shared_oe == 16'hFFFF &&
    o_shared_addr_data_port == $past(addr_q[DATA_W-1:0]))
    else $error("muxed address missing");
  seg64_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_space_size == SPACE_64K) |=> o_segment_port == 8'h00)
    else $error("segment lines in 64K space");
  grant_dir_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_arbitration_enable_bit && slave) |=> !o_bus_grant_ack_oe)
    else $error("slave still drives grant");

endmodule : external_bus_unit

/* File: test/ext_mem_model.sv */
// Partner model: external memory with address latch and ready answer
module ext_mem_model
  import ebu_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_mux,
  input  wire logic              i_rdy_pol,
  input  wire logic [3:0]        i_rdy_dly,
  input  wire logic              i_ale,
  input  wire logic              i_rd_n,
  input  wire logic              i_wr_n,
  input  wire logic [DATA_W-1:0] i_addr_port,
  input  wire logic [DATA_W-1:0] i_bus,
  output logic [DATA_W-1:0]      o_bus,
  output logic                   o_ready,
  output logic [DATA_W-1:0]      o_addr
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [DATA_W-1:0] mem [256];
  logic [DATA_W-1:0] idle = 16'hA5C3;
  logic [3:0]        cnt  = 4'h0;

  always @(posedge i_clk) begin
    idle <= ~idle;
    if (i_ale) o_addr <= i_mux ? i_bus : i_addr_port;
    if (!i_wr_n) mem[o_addr[7:0]] <= i_bus;
    cnt <= (i_rd_n && i_wr_n) ? 4'h0 : (cnt == 4'hF) ? cnt : cnt + 4'h1;
  end

  // Released bus shows a changing pattern, never its last value
  assign o_bus   = !i_rd_n ? mem[o_addr[7:0]] : idle;
  // Inactive level until the strobe has lasted the chosen count
  assign o_ready = (cnt >= i_rdy_dly) ? i_rdy_pol : !i_rdy_pol;
endmodule : ext_mem_model

/* File: test/external_bus_unit_bench.sv */
// Self-checking bench for the external bus unit with a memory model
module external_bus_unit_bench
  import ebu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic                      clk = 1'b0, rst_n = 1'b0, req = 1'b0, we = 1'b0, byt = 1'b0;
  logic                      cssel = 1'b0, arb = 1'b0, dir = 1'b0, hold_n = 1'b1;
  logic                      gack_in = 1'b1, mux = 1'b0, rpol = 1'b1;
  logic [3:0]                rdly = 4'h0;
  logic [1:0]                space = SPACE_16M;
  logic [ADDR_W-1:0]         addr = '0, a;
  logic [DATA_W-1:0]         wdata = '0, rdata, shp, shoe, dap, mbus, shin, maddr, rv, d;
  logic [CFG_W-1:0]          dcfg = '0;
  logic [NUM_WIN*CFG_W-1:0]  wcfg = '0;
  logic [NUM_WIN*ADDR_W-1:0] wsel = '0, wmask = '0;
  logic [NUM_WIN:0]          cs_n, cs_seen;
  logic [SEG_W-1:0]          seg, seg_seen;
  logic                      ack, ale, rd_n, wr_n, rdy, bus_request_out_n, gack, gack_oe, busy, bsy_seen;
  int                        err_count = 0, checks = 0, cyc = 0;
  int                        t_ale = -1, t_cs = -1, lat, lat0;
  logic [ADDR_W-1:0]         wtab [5] = '{24'h150000, 24'h10ABCD, 24'h250000, 24'h208123,
                                          24'h050000};
  logic [SEG_W-1:0]          segm [4] = '{8'hFF, 8'h0F, 8'h03, 8'h00};

  always #4 clk = ~clk;
  assign shin = (shoe & shp) | (~shoe & mbus);

  external_bus_unit u_external_bus_unit (
    .i_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_we(we), .i_byte(byt), .i_addr(addr),
    .i_wdata(wdata), .o_ack(ack), .o_rdata(rdata), .i_default_bus_config(dcfg),
    .i_window_bus_config(wcfg), .i_window_address_select(wsel), .i_window_mask(wmask),
    .i_space_size(space), .i_chip_select_timing_sel(cssel),
    .i_arbitration_enable_bit(arb), .i_grant_pin_direction_bit(dir),
    .o_shared_addr_data_port(shp), .o_shared_oe(shoe), .i_shared_addr_data_port(shin),
    .o_dedicated_address_port(dap), .o_segment_port(seg), .o_ale(ale), .o_rd_n(rd_n),
    .o_wr_n(wr_n), .o_cs_n(cs_n), .i_ready(rdy), .i_hold_n(hold_n),
    .o_bus_request_out_n(bus_request_out_n), .o_bus_grant_ack(gack), .o_bus_grant_ack_oe(gack_oe),
    .i_bus_grant_ack(gack_in), .o_busy(busy));

  ext_mem_model u_ext_mem_model (
    .i_clk(clk), .i_mux(mux), .i_rdy_pol(rpol), .i_rdy_dly(rdly), .i_ale(ale),
    .i_rd_n(rd_n), .i_wr_n(wr_n), .i_addr_port(dap), .i_bus(shp), .o_bus(mbus),
    .o_ready(rdy), .o_addr(maddr));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Falling edge sampling keeps the monitor clear of register updates
  always @(negedge clk) begin
    cyc++;
    if (ale === 1'b1 && t_ale < 0) begin
      t_ale = cyc;
      seg_seen = seg;
      bsy_seen = busy;
    end
    if (cs_n !== CS_IDLE && t_cs < 0) begin
      t_cs = cyc;
      cs_seen = cs_n;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  function automatic logic [CFG_W-1:0] cfg(input logic [2:0] m, input logic [3:0] ws,
                                           input logic [5:0] f);
    return {3'h0, f, ws, m};
  endfunction : cfg

  // Highest matching window wins; no match selects the default line
  function automatic logic [NUM_WIN:0] exp_cs(input logic [ADDR_W-1:0] x);
    exp_cs = 5'h1E;
    for (int k = 0; k < NUM_WIN; k++)
      if (((x ^ wsel[k*ADDR_W +: ADDR_W]) & wmask[k*ADDR_W +: ADDR_W]) == '0)
        exp_cs = ~(5'h01 << (k + 1));
  endfunction : exp_cs

  task automatic access(input logic w, input logic [ADDR_W-1:0] x, input logic [DATA_W-1:0] v);
    @(posedge clk);
    t_ale = -1;
    t_cs = -1;
    lat = 0;
    @(negedge clk);
    req = 1'b1;
    we = w;
    addr = x;
    wdata = v;
    do begin
      @(posedge clk);
      #1;
      lat++;
    end while (ack !== 1'b1 && lat < 300);
    rv = rdata;
    if (lat >= 300) check("ack", 0, 1);
    @(negedge clk);
    req = 1'b0;
    repeat (6) @(negedge clk);
  endtask : access

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    stop_test();
  end

  initial begin
    void'($urandom(32'hDEB83FF8));
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    check("cs idle", cs_n, CS_IDLE);
    check("strobes", {rd_n, wr_n, shoe}, 18'h30000);
    check("master", {gack, gack_oe, bus_request_out_n}, 3'h7);
    check("busy idle", busy, 1'b0);
    wsel  = {24'h208000, 24'h200000, 24'h100000, 24'h100000};
    wmask = {24'hFFF000, 24'hF00000, 24'hFF0000, 24'hF00000};
    wcfg  = {4{cfg(MODE_DEMUX16, 4'h0, 6'h20)}};
    dcfg  = cfg(MODE_DEMUX16, 4'h0, 6'h20);
    foreach (wtab[i]) begin
      d = 16'($urandom());
      access(1'b1, wtab[i], d);
      check("window cs", cs_seen, exp_cs(wtab[i]));
      check("busy", bsy_seen, 1'b1);
      access(1'b0, wtab[i], 16'h0000);
      check("window rd", rv, d);
    end
    for (int m = 1; m <= 4; m++) begin
      dcfg = cfg(m[2:0], 4'h0, 6'h20);
      mux = (m == 2 || m == 3);
      a = {4'h0, 20'($urandom())};
      d = 16'($urandom());
      access(1'b1, a, d);
      check("addr out", maddr, a[15:0]);
      access(1'b0, a, 16'h0000);
      check("mode rd", rv, (m >= 3) ? {8'h00, d[7:0]} : d);
    end
    mux = 1'b0;
    dcfg = cfg(MODE_SINGLE, 4'h0, 6'h20);
    access(1'b0, 24'h050000, 16'h0000);
    check("single ale", t_ale, 32'hFFFFFFFF);
    check("single cs", t_cs, 32'hFFFFFFFF);
    dcfg = cfg(MODE_DEMUX16, 4'h0, 6'h20);
    access(1'b0, 24'h050000, 16'h0000);
    lat0 = lat;
    for (int k = 0; k < 3; k++) begin
      dcfg = cfg(MODE_DEMUX16, (k == 0) ? 4'h7 : 4'h0, (k == 1) ? 6'h22 : (k == 2) ? 6'h24 : 6'h20);
      access(1'b0, 24'h050000, 16'h0000);
      check("cycle len", lat - lat0, (k == 0) ? 7 : 1);
    end
    dcfg = cfg(MODE_DEMUX16, 4'h0, 6'h20);
    for (int k = 0; k < 2; k++) begin
      cssel = k[0];
      access(1'b0, 24'h050000, 16'h0000);
      check("cs delay", t_cs - t_ale, 1 - k);
    end
    cssel = 1'b0;
    foreach (segm[s]) begin
      space = s[1:0];
      access(1'b0, 24'hA51234, 16'h0000);
      check("segment", seg_seen, 8'hA5 & segm[s]);
    end
    space = SPACE_16M;
    rpol = 1'($urandom());
    rdly = 4'h6;
    dcfg = cfg(MODE_DEMUX16, 4'h0, {1'b1, rpol, 4'h8});
    access(1'b0, 24'h050000, 16'h0000);
    check("rdy wait", lat >= lat0 + 6, 1);
    rdly = 4'hF;
    dcfg = cfg(MODE_DEMUX16, 4'h0, {1'b1, rpol, 4'h0});
    access(1'b0, 24'h050000, 16'h0000);
    check("no rdy", lat, lat0);
    hold_n = 1'b0;
    repeat (10) @(negedge clk);
    check("hold off", gack, 1'b1);
    arb = 1'b1;
    for (int n = 0; n < 20 && gack !== 1'b0; n++) @(negedge clk);
    check("hold on", gack, 1'b0);
    req = 1'b1;
    we = 1'b0;
    addr = 24'h050000;
    repeat (2) @(negedge clk);
    check("bus request", bus_request_out_n, 1'b0);
    hold_n = 1'b1;
    for (int n = 0; n < 20 && gack !== 1'b1; n++) @(negedge clk);
    check("released", {gack, bus_request_out_n}, 2'h3);
    for (int n = 0; n < 20 && ack !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    check("held request", ack, 1'b1);
    @(negedge clk);
    req = 1'b0;
    repeat (6) @(negedge clk);
    dir = 1'b1;
    repeat (4) @(negedge clk);
    check("slave", gack_oe, 1'b0);
    stop_test();
  end
endmodule : external_bus_unit_bench
